// *** logic/line_ctl_defines.svh ***
/*
 * Offsets, field positions and reset values of the per-line protocol
 * control registers. Assumes an 8-bit register address {line, index}.
 */
`ifndef LINE_CTL_DEFINES_SVH
`define LINE_CTL_DEFINES_SVH

// ****************************************
// Register indices (low address nibble)
// ****************************************
`define IDX_IRQ_STATUS 4'h0
`define IDX_IRQ_MASK 4'h1
`define IDX_RESUME 4'h2
`define IDX_PROTOCOL 4'hA
`define IDX_LINE_STATE 4'hB
`define IDX_TX_MODE 4'hC
`define IDX_RX_MODE 4'hD
`define IDX_PROGRESS 4'hE
`define IDX_CTL_HOLD 4'hF

// ****************************************
// Field positions
// ****************************************
`define PROTO_IDLE_MARK 0
`define PROTO_STRIP_SYNC 1
`define PROTO_CHECK_LO 3
`define PROTO_CHECK_HI 4
`define PROTO_RX_BYPASS 5
`define PROTO_TX_BYPASS 6
`define NEXT_MODE_LO 13
`define NEXT_MODE_HI 15
`define CHECK_FLAG 10
`define CTL_IRQ_BIT 0
`define CTL_DISCARD_BIT 4
`define RESUME_BIT 0

// ****************************************
// Writable masks and reset values
// ****************************************
`define PROTO_MASK 16'hFF7B
`define NEXT_MASK 16'hE400
`define PROTO_RESET 16'h0000
`define NEXT_RESET 16'h0000
`define MODE_RESET 3'h0
`define CTL_RESET 8'h00
`define IRQ_COUNT 4

`endif

// *** logic/line_ctl_pkg.sv ***
/*
 * Types shared by the line control block.
 * Assumes the defines header is compiled alongside.
 */
package line_ctl_pkg;

	// Block check kinds, order follows the two-bit field code
	typedef enum logic [1:0] {
		CHECK_LRC8,
		CHECK_CRC16,
		CHECK_UNUSED16,
		CHECK_CCITT
	} check_type;

	// Leading-sync stripper states
	typedef enum logic {
		STRIP_IDLE,
		STRIP_ACTIVE
	} strip_state_type;

endpackage : line_ctl_pkg

// *** logic/sync_strip.sv ***
/*
 * Per-line receive sync stripper: decides whether a received character
 * goes to the receive buffer. Assumes one character pulse per cycle.
 */
`timescale 1ns/1ns
module sync_strip (
	input wire logic clk,
	input wire logic reset,
	input wire logic strip_enable,
	input wire logic rx_valid,
	input wire logic rx_is_sync,
	input wire logic sync_found,
	output logic keep,
	output logic strip_on
);
	import line_ctl_pkg::*;

	line_ctl_pkg::strip_state_type state_ff;
	line_ctl_pkg::strip_state_type nxt_state;

	// ****************************************
	// Stripping window
	// ****************************************
	// Sync acquisition chars never stored; leading syncs dropped in window
	assign keep = rx_valid && !sync_found && !(state_ff == STRIP_ACTIVE && rx_is_sync);
	assign strip_on = (state_ff == STRIP_ACTIVE);

	// Window opens on sync, closes on first non-sync character
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			STRIP_IDLE: begin
				if (sync_found && strip_enable)
					nxt_state = STRIP_ACTIVE;
			end
			STRIP_ACTIVE: begin
				if (rx_valid && !rx_is_sync && !sync_found)
					nxt_state = STRIP_IDLE;
			end
			default: nxt_state = STRIP_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			state_ff <= STRIP_IDLE;
		else
			state_ff <= nxt_state;
	end

endmodule : sync_strip

// *** logic/event_irq.sv ***
/*
 * Sticky event status with mask and one level interrupt.
 * Assumes write-one-to-clear strobes from the register decoder.
 */
`timescale 1ns/1ns
module event_irq #(
	parameter int N = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [N-1:0] set,
	input wire logic clr_wr,
	input wire logic mask_wr,
	input wire logic [N-1:0] wdata,
	output logic [N-1:0] status_ff,
	output logic [N-1:0] mask_ff,
	output logic irq
);
	logic [N-1:0] nxt_status;

	// Set wins over a clear landing in the same cycle
	assign nxt_status = (status_ff & ~(clr_wr ? wdata : '0)) | set;
	assign irq = |(status_ff & mask_ff);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status_ff <= '0;
			mask_ff <= '0;
		end else begin
			status_ff <= nxt_status;
			if (mask_wr)
				mask_ff <= wdata;
		end
	end

endmodule : event_irq

// *** logic/line_protocol_control_regs.sv ***
/*
 * Per-line protocol control registers of a multi-line synchronous
 * communications controller, with the decisions the character processor
 * draws from them. Assumes the processor presents one line at a time on
 * proc_line with one-cycle event pulses, and a plain host register port.
 */
// Design decision made here: the plain strobed port.
// Functional notes
// - Transmit mode field selects transmit table.
// - Receive mode field selects receive table.
// - On resume, held control byte disposes character.
// - Processor may store discard-only byte, mode kept.
// - Held byte stored with interrupt bit cleared.
// - Idle-mark: mark after last character when counts zero.
// - Idle-mark clear: sync idles, async holds mark.
// - Strip leading syncs after sync when enabled.
// - Sync acquisition characters always discarded.
// - Two-bit field selects block check kind.
// - Receive bypass in mode zero skips fetch.
// - Transmit bypass in mode zero skips fetch.
// - Line state keeps next rx mode, expect-check.
// - Line progress keeps next tx mode, send-check.
// - Discard bit prevents storing the character.
`timescale 1ns/1ns
`include "line_ctl_defines.svh"
module line_protocol_control_regs #(
	parameter int NUM_LINES = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [15:0] rdata,
	output logic irq,
	input wire logic [3:0] proc_line,
	input wire logic line_is_sync,
	input wire logic tx_counts_zero,
	input wire logic tx_char_done,
	input wire logic tx_marked_zero,
	input wire logic rx_marked_zero,
	input wire logic rx_valid,
	input wire logic rx_is_sync,
	input wire logic sync_found,
	input wire logic proc_ctl_wr,
	input wire logic [7:0] proc_ctl_byte,
	input wire logic proc_discard_wr,
	output logic [2:0] tx_mode,
	output logic [2:0] rx_mode,
	output line_ctl_pkg::check_type check_kind,
	output logic tx_fetch_skip,
	output logic rx_fetch_skip,
	output logic drive_mark,
	output logic send_idle_sync,
	output logic rx_store,
	output logic strip_on,
	output logic expect_check,
	output logic send_check,
	output logic resume_ff,
	output logic [3:0] resume_line_ff,
	output logic [7:0] resume_byte_ff,
	output logic resume_discard_ff
);
	import line_ctl_pkg::*;

	// ****************************************
	// Parameter check
	// ****************************************
	// Line number travels in one address nibble
	if (NUM_LINES < 1 || NUM_LINES > 16) begin : g_bad_lines
		$error("NUM_LINES must be 1 to 16");
	end

	// Two-bit field code maps straight onto the check kind
	function automatic check_type decode_check(input logic [15:0] proto);
		return check_type'({proto[`PROTO_CHECK_HI], proto[`PROTO_CHECK_LO]});
	endfunction : decode_check

	// ****************************************
	// Per-line storage
	// ****************************************
	logic [15:0] proto_ff [NUM_LINES];
	logic [15:0] state_ff [NUM_LINES];
	logic [15:0] progress_ff [NUM_LINES];
	logic [2:0] txm_ff [NUM_LINES];
	logic [2:0] rxm_ff [NUM_LINES];
	logic [7:0] hold_ff [NUM_LINES];
	logic [NUM_LINES-1:0] mark_ff;
	logic [NUM_LINES-1:0] keep_vec;
	logic [NUM_LINES-1:0] strip_vec;
	logic [15:0] rdata_ff;

	// ****************************************
	// Host address decode
	// ****************************************
	wire [3:0] host_line = addr[7:4];
	wire [3:0] host_idx = addr[3:0];
	wire host_line_ok = 32'(host_line) < NUM_LINES;
	wire wr_proto = wr_stb && host_idx == `IDX_PROTOCOL;
	wire wr_state = wr_stb && host_idx == `IDX_LINE_STATE;
	wire wr_txm = wr_stb && host_idx == `IDX_TX_MODE;
	wire wr_rxm = wr_stb && host_idx == `IDX_RX_MODE;
	wire wr_prog = wr_stb && host_idx == `IDX_PROGRESS;
	wire wr_hold = wr_stb && host_idx == `IDX_CTL_HOLD;
	wire wr_clr = wr_stb && host_idx == `IDX_IRQ_STATUS;
	wire wr_mask = wr_stb && host_idx == `IDX_IRQ_MASK;
	wire wr_resume = wr_stb && host_idx == `IDX_RESUME && wdata[`RESUME_BIT];

	// ****************************************
	// Per-line update logic
	// ****************************************
	for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
		wire host_hit = host_line == 4'(g);
		wire proc_hit = proc_line == 4'(g);
		wire [15:0] proto = proto_ff[g];
		wire idle_bit = proto[`PROTO_IDLE_MARK];
		wire [2:0] nxt_txm;
		wire [2:0] nxt_rxm;
		wire [7:0] nxt_hold;
		wire nxt_mark;

		// Marked count at zero loads next mode; it beats a host write
		assign nxt_txm = (proc_hit && tx_marked_zero) ?
			progress_ff[g][`NEXT_MODE_HI:`NEXT_MODE_LO] :
			(wr_txm && host_hit) ? wdata[2:0] : txm_ff[g];
		assign nxt_rxm = (proc_hit && rx_marked_zero) ?
			state_ff[g][`NEXT_MODE_HI:`NEXT_MODE_LO] :
			(wr_rxm && host_hit) ? wdata[2:0] : rxm_ff[g];

		// Every store clears the interrupt bit; discard-only keeps mode
		assign nxt_hold = (proc_hit && proc_ctl_wr) ?
			(proc_ctl_byte & ~8'h01) :
			(proc_hit && proc_discard_wr) ?
			((hold_ff[g] & ~8'h01) | 8'h10) :
			(wr_hold && host_hit) ? (wdata[7:0] & ~8'h01) :
			hold_ff[g];

		// Mark latches when the last character finishes, drops on new data
		assign nxt_mark = !tx_counts_zero && proc_hit ? 1'b0 :
			(proc_hit && tx_char_done && idle_bit) ? 1'b1 :
			mark_ff[g] && idle_bit;

		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				proto_ff[g] <= `PROTO_RESET;
				state_ff[g] <= `NEXT_RESET;
				progress_ff[g] <= `NEXT_RESET;
				txm_ff[g] <= `MODE_RESET;
				rxm_ff[g] <= `MODE_RESET;
				hold_ff[g] <= `CTL_RESET;
				mark_ff[g] <= 1'b0;
			end else begin
				if (wr_proto && host_hit)
					proto_ff[g] <= wdata & `PROTO_MASK;
				if (wr_state && host_hit)
					state_ff[g] <= wdata & `NEXT_MASK;
				if (wr_prog && host_hit)
					progress_ff[g] <= wdata & `NEXT_MASK;
				txm_ff[g] <= nxt_txm;
				rxm_ff[g] <= nxt_rxm;
				hold_ff[g] <= nxt_hold;
				mark_ff[g] <= nxt_mark;
			end
		end

		// Each line keeps its own stripping window
		sync_strip u_strip (
			.clk(clk),
			.reset(reset),
			.strip_enable(proto[`PROTO_STRIP_SYNC]),
			.rx_valid(rx_valid && proc_hit),
			.rx_is_sync(rx_is_sync),
			.sync_found(sync_found && proc_hit),
			.keep(keep_vec[g]),
			.strip_on(strip_vec[g])
		);
	end

	// ****************************************
	// Processor-facing selection
	// ****************************************
	wire line_ok = 32'(proc_line) < NUM_LINES;
	wire [3:0] pl = line_ok ? proc_line : 4'h0;
	wire [15:0] cur_proto = proto_ff[pl];
	wire cur_idle_bit = cur_proto[`PROTO_IDLE_MARK];

	assign tx_mode = txm_ff[pl];
	assign rx_mode = rxm_ff[pl];
	// Unused code passes through; accumulator runs without a polynomial
	assign check_kind = decode_check(cur_proto);
	assign tx_fetch_skip = cur_proto[`PROTO_TX_BYPASS] && txm_ff[pl] == 3'h0;
	assign rx_fetch_skip = cur_proto[`PROTO_RX_BYPASS] && rxm_ff[pl] == 3'h0;
	// Idle with bit clear: sync lines idle syncs, async lines sit at mark
	assign send_idle_sync = tx_counts_zero && !cur_idle_bit && line_is_sync;
	// Latched mark ignored at once when the idle bit is cleared
	assign drive_mark = (mark_ff[pl] && cur_idle_bit) ||
		(tx_counts_zero && !cur_idle_bit && !line_is_sync);
	assign rx_store = line_ok && keep_vec[pl];
	assign strip_on = strip_vec[pl];
	assign expect_check = state_ff[pl][`CHECK_FLAG];
	assign send_check = progress_ff[pl][`CHECK_FLAG];

	// ****************************************
	// Resume and disposition
	// ****************************************
	// Held byte is sampled at the resume write; a same-cycle store is missed
	wire [3:0] rl = host_line_ok ? host_line : 4'h0;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			resume_ff <= 1'b0;
			resume_line_ff <= 4'h0;
			resume_byte_ff <= 8'h00;
			resume_discard_ff <= 1'b0;
		end else begin
			resume_ff <= wr_resume && host_line_ok;
			if (wr_resume && host_line_ok) begin
				resume_line_ff <= host_line;
				resume_byte_ff <= hold_ff[rl];
				resume_discard_ff <= hold_ff[rl][`CTL_DISCARD_BIT];
			end
		end
	end

	// ****************************************
	// Interrupt events
	// ****************************************
	// 0: mark entered, 1: rx marked zero, 2: tx marked zero, 3: discard stored
	logic [`IRQ_COUNT-1:0] irq_status;
	logic [`IRQ_COUNT-1:0] irq_mask;
	wire [`IRQ_COUNT-1:0] irq_set = {
		proc_discard_wr && line_ok,
		tx_marked_zero && line_ok,
		rx_marked_zero && line_ok,
		line_ok && !mark_ff[pl] && tx_char_done && tx_counts_zero && cur_idle_bit
	};

	event_irq #(
		.N(`IRQ_COUNT)
	) u_irq (
		.clk(clk),
		.reset(reset),
		.set(irq_set),
		.clr_wr(wr_clr),
		.mask_wr(wr_mask),
		.wdata(wdata[`IRQ_COUNT-1:0]),
		.status_ff(irq_status),
		.mask_ff(irq_mask),
		.irq(irq)
	);

	// ****************************************
	// Read path
	// ****************************************
	// Unmapped indices read as zero; absent lines too, except the shared status and mask
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		case (host_idx)
			`IDX_IRQ_STATUS: rd_mux = 16'(irq_status);
			`IDX_IRQ_MASK: rd_mux = 16'(irq_mask);
			`IDX_PROTOCOL: rd_mux = host_line_ok ? proto_ff[rl] : 16'h0000;
			`IDX_LINE_STATE: rd_mux = host_line_ok ? state_ff[rl] : 16'h0000;
			`IDX_TX_MODE: rd_mux = host_line_ok ? 16'(txm_ff[rl]) : 16'h0000;
			`IDX_RX_MODE: rd_mux = host_line_ok ? 16'(rxm_ff[rl]) : 16'h0000;
			`IDX_PROGRESS: rd_mux = host_line_ok ? progress_ff[rl] : 16'h0000;
			`IDX_CTL_HOLD: rd_mux = host_line_ok ? 16'(hold_ff[rl]) : 16'h0000;
			default: rd_mux = 16'h0000;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rdata_ff <= 16'h0000;
		else
			rdata_ff <= rd_stb ? rd_mux : 16'h0000;
	end
	assign rdata = rdata_ff;

endmodule : line_protocol_control_regs

// *** tb/line_peer_model.sv ***
/*
 * Remote station model: one received frame per start pulse, given as
 * character events of the line under test. Assumes a single clock.
 */
`timescale 1ns/1ns
module line_peer_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	output logic rx_valid,
	output logic rx_is_sync,
	output logic sync_found
);
	// ****************************************
	// Frame sequencer
	// ****************************************
	// Two bits a character, first lowest: {is sync, completes sync}
	localparam logic [11:0] frame_bits = 12'h22B;
	logic [2:0] idx_ff;
	logic toggle_ff;
	logic [3:0] pick;
	// Idle sync flag toggles so that no stale value lingers
	assign pick = {idx_ff - 3'h1, 1'b0};
	assign rx_valid = idx_ff != 3'h0;
	assign rx_is_sync = rx_valid ? frame_bits[pick + 4'h1] : toggle_ff;
	assign sync_found = rx_valid & frame_bits[pick];
	// Characters come back to back, one each clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			idx_ff <= 3'h0;
			toggle_ff <= 1'b0;
		end else begin
			toggle_ff <= ~toggle_ff;
			if (idx_ff == 3'h6) idx_ff <= 3'h0;
			else if (idx_ff != 3'h0 || start) idx_ff <= idx_ff + 3'h1;
		end
	end
endmodule : line_peer_model

// *** tb/line_ctl_props.sv ***
/*
 * Checker for the line control block: bus, resume, store and idle rules.
 * Assumes it is bound onto the block's ports.
 */
`timescale 1ns/1ns
module line_ctl_props (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [15:0] rdata,
	input wire logic irq,
	input wire logic rx_valid,
	input wire logic sync_found,
	input wire logic rx_store,
	input wire logic tx_counts_zero,
	input wire logic line_is_sync,
	input wire logic send_idle_sync,
	input wire logic drive_mark,
	input wire logic resume_ff,
	input wire logic [3:0] resume_line_ff,
	input wire logic [7:0] resume_byte_ff,
	input wire logic resume_discard_ff
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Resume write, then a pulse of exactly one cycle
	sequence s_go; wr_stb && addr[3:0] == 4'h2 && wdata[0]; endsequence
	sequence s_pulse; resume_ff ##1 !resume_ff; endsequence
	property p_resume; s_go |=> resume_line_ff == $past(addr[7:4]) ##0 s_pulse; endproperty
	a_resume: assert property (p_resume) else $error("resume pulse wrong");
	property p_disc; resume_ff |-> resume_discard_ff == resume_byte_ff[4]; endproperty
	a_disc: assert property (p_disc) else $error("discard flag wrong");
	property p_rd_idle; !rd_stb |=> rdata == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_unmapped; rd_stb && addr[3:0] inside {[4'h3:4'h9]} |=> rdata == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_mode_rd; rd_stb && addr[3:1] == 3'h6 |=> rdata[15:3] == 13'h0000; endproperty
	a_mode_rd: assert property (p_mode_rd) else $error("mode read too wide");
	property p_hold_rd; rd_stb && addr[3:0] == 4'hF |=> rdata[15:8] == 8'h00 && !rdata[0];
	endproperty
	a_hold_rd: assert property (p_hold_rd) else $error("hold read wrong");
	property p_sync_drop; rx_valid && sync_found |-> !rx_store; endproperty
	a_sync_drop: assert property (p_sync_drop) else $error("sync char stored");
	property p_no_store; !rx_valid |-> !rx_store; endproperty
	a_no_store: assert property (p_no_store) else $error("store without char");
	property p_idle_sync; send_idle_sync |-> tx_counts_zero && line_is_sync && !drive_mark;
	endproperty
	a_idle_sync: assert property (p_idle_sync) else $error("idle sync wrong");
	property p_mask; wr_stb && addr[3:0] == 4'h1 && wdata[3:0] == 4'h0 |=> !irq; endproperty
	a_mask: assert property (p_mask) else $error("masked irq high");
endmodule : line_ctl_props
bind line_protocol_control_regs line_ctl_props u_props (.clk, .reset, .addr, .wdata, .wr_stb,
	.rd_stb, .rdata, .irq, .rx_valid, .sync_found, .rx_store, .tx_counts_zero, .line_is_sync,
	.send_idle_sync, .drive_mark, .resume_ff, .resume_line_ff, .resume_byte_ff,
	.resume_discard_ff);

// *** tb/test_line_protocol_control_regs.sv ***
/*
 * Self-checking bench of the line control block, line 3 under test.
 * Assumes the remote station model and the bound checker.
 */
`timescale 1ns/1ns
module test_line_protocol_control_regs;
	import line_ctl_pkg::*;
	logic clk = 1'b0, reset = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, rd_pend = 1'b0;
	logic start = 1'b0, line_is_sync = 1'b0, tx_counts_zero = 1'b0, tx_char_done = 1'b0;
	logic tx_marked_zero = 1'b0, rx_marked_zero = 1'b0, proc_ctl_wr = 1'b0;
	logic proc_discard_wr = 1'b0;
	logic [7:0] addr = 8'h00, proc_ctl_byte = 8'h00, resume_byte_ff;
	logic [3:0] proc_line = 4'h3, resume_line_ff;
	logic [15:0] wdata = 16'h0000, rdata, rnd = 16'h625E; // Seed 25182
	logic irq, rx_valid, rx_is_sync, sync_found, tx_fetch_skip, rx_fetch_skip, rx_store;
	logic drive_mark, send_idle_sync, strip_on, expect_check, send_check;
	logic resume_ff, resume_discard_ff;
	logic [2:0] tx_mode, rx_mode;
	check_type check_kind;
	logic [15:0] q_rd[$], q_rx[$];
	logic [15:0] masks[6] = '{16'hFF7B, 16'hE400, 16'h0007, 16'h0007, 16'hE400, 16'h00FE};
	logic [5:0] exp_rx[2] = '{6'h3E, 6'h38};
	int failures = 0, n_compared = 0;

	line_protocol_control_regs #(.NUM_LINES(12)) uut (.clk, .reset, .addr, .wdata, .wr_stb,
		.rd_stb, .rdata, .irq, .proc_line, .line_is_sync, .tx_counts_zero, .tx_char_done,
		.tx_marked_zero, .rx_marked_zero, .rx_valid, .rx_is_sync, .sync_found, .proc_ctl_wr,
		.proc_ctl_byte, .proc_discard_wr, .tx_mode, .rx_mode, .check_kind, .tx_fetch_skip,
		.rx_fetch_skip, .drive_mark, .send_idle_sync, .rx_store, .strip_on, .expect_check,
		.send_check, .resume_ff, .resume_line_ff, .resume_byte_ff, .resume_discard_ff);
	line_peer_model peer (.clk, .reset, .start, .rx_valid, .rx_is_sync, .sync_found);

	// ****************************************
	// Helpers
	// ****************************************
	always #10 clk = ~clk;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Two cycles an access, so a strobe is never set twice in one step
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		q_rd.push_back(e);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(posedge clk);
	endtask : rd
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	// Watcher: read data and store decisions against the oldest note
	always @(posedge clk) rd_pend <= rd_stb;
	always @(negedge clk) begin
		if (rd_pend) chk(rdata, q_rd.pop_front());
		if (rx_valid) chk({15'h0000, rx_store}, q_rx.pop_front());
	end
	// Watchdog, far beyond the roughly 150 cycles the tests need
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		summarize();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (int i = 10; i < 16; i++) rd({4'h3, i[3:0]}, 16'h0000);
		rd(8'h35, 16'h0000);
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			wr({4'h3, 4'hA + k[3:0]}, rnd);
			rd({4'h3, 4'hA + k[3:0]}, rnd & masks[k]);
		end
		wr(8'h36, rnd);
		rd(8'h36, 16'h0000);
		wr(8'hCA, 16'hFFFF);
		rd(8'hCA, 16'h0000);
		$display("test masks done");
		wr(8'h3C, 16'h0000);
		wr(8'h3D, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			wr(8'h3A, 16'h0060 | (c[15:0] << 3));
			@(negedge clk);
			chk({14'h0000, check_kind}, c[15:0]);
			chk({14'h0000, tx_fetch_skip, rx_fetch_skip}, 16'h0003);
			@(posedge clk);
		end
		wr(8'h3C, 16'h0005);
		wr(8'h3D, 16'h0002);
		@(negedge clk);
		chk({13'h0000, tx_mode}, 16'h0005);
		chk({13'h0000, rx_mode}, 16'h0002);
		chk({14'h0000, tx_fetch_skip, rx_fetch_skip}, 16'h0000);
		@(posedge clk);
		proc_line <= 4'h5;
		@(negedge clk);
		chk({13'h0000, tx_mode}, 16'h0000);
		@(posedge clk);
		proc_line <= 4'h3;
		$display("test modes done");
		wr(8'h3B, 16'hA400);
		wr(8'h3E, 16'h6400);
		wr(8'h31, 16'h000F);
		rx_marked_zero <= 1'b1;
		tx_marked_zero <= 1'b1;
		@(posedge clk);
		rx_marked_zero <= 1'b0;
		tx_marked_zero <= 1'b0;
		@(negedge clk);
		chk({13'h0000, rx_mode}, 16'h0005);
		chk({13'h0000, tx_mode}, 16'h0003);
		chk({14'h0000, expect_check, send_check}, 16'h0003);
		chk({15'h0000, irq}, 16'h0001);
		@(posedge clk);
		rd(8'h30, 16'h0006);
		wr(8'h30, 16'h0006);
		rd(8'h30, 16'h0000);
		$display("test marked counts done");
		wr(8'h3A, 16'h0001);
		tx_counts_zero <= 1'b1;
		@(negedge clk);
		chk({15'h0000, drive_mark}, 16'h0000);
		@(posedge clk);
		tx_char_done <= 1'b1;
		@(posedge clk);
		tx_char_done <= 1'b0;
		@(negedge clk);
		chk({15'h0000, drive_mark}, 16'h0001);
		@(posedge clk);
		wr(8'h3A, 16'h0000);
		line_is_sync <= 1'b1;
		@(negedge clk);
		chk({14'h0000, send_idle_sync, drive_mark}, 16'h0002);
		@(posedge clk);
		line_is_sync <= 1'b0;
		@(negedge clk);
		chk({14'h0000, send_idle_sync, drive_mark}, 16'h0001);
		@(posedge clk);
		tx_counts_zero <= 1'b0;
		rd(8'h30, 16'h0001);
		wr(8'h30, 16'h0001);
		$display("test idle done");
		for (int s = 0; s < 2; s++) begin
			wr(8'h3A, s[0] ? 16'h0002 : 16'h0000);
			for (int j = 0; j < 6; j++) q_rx.push_back({15'h0000, exp_rx[s][j]});
			start <= 1'b1;
			@(posedge clk);
			start <= 1'b0;
			@(posedge clk);
			@(negedge clk);
			chk({15'h0000, strip_on}, {15'h0000, s[0]});
			repeat (7) @(posedge clk);
		end
		$display("test sync strip done");
		wr(8'h3F, 16'h0025);
		rd(8'h3F, 16'h0024);
		wr(8'h32, 16'h0001);
		@(negedge clk);
		chk({3'h0, resume_discard_ff, resume_line_ff, resume_byte_ff}, 16'h0324);
		@(posedge clk);
		proc_discard_wr <= 1'b1;
		@(posedge clk);
		proc_discard_wr <= 1'b0;
		@(posedge clk);
		rd(8'h3F, 16'h0034);
		wr(8'h32, 16'h0001);
		@(negedge clk);
		chk({3'h0, resume_discard_ff, resume_line_ff, resume_byte_ff}, 16'h1334);
		@(posedge clk);
		proc_ctl_byte <= 8'h81;
		proc_ctl_wr <= 1'b1;
		@(posedge clk);
		proc_ctl_wr <= 1'b0;
		@(posedge clk);
		rd(8'h3F, 16'h0080);
		rd(8'h30, 16'h0008);
		wr(8'h31, 16'h0000);
		@(negedge clk);
		chk({15'h0000, irq}, 16'h0000);
		$display("test control byte done");
		summarize();
	end
endmodule : test_line_protocol_control_regs
